// ---- inc/srb_pkg.sv ----
package srb_pkg;

  // address space
  localparam logic [15:0] ADDR_LAST     = 16'h0e3f;
  localparam int unsigned MEM_DEPTH     = 3648;
  localparam logic [15:0] OFS_PORT_CTL  = 16'h0000;
  localparam logic [15:0] OFS_RSVD      = 16'h0001;
  localparam logic [15:0] OFS_REV       = 16'h0002;
  localparam logic [15:0] OFS_DEV_ID    = 16'h0003;
  localparam logic [15:0] OFS_READBACK  = 16'h0004;
  localparam logic [15:0] OFS_COMMIT    = 16'h0005;
  localparam logic [15:0] OFS_STATUS    = 16'h0006;
  localparam logic [15:0] OFS_S_FIRST   = 16'h0100;
  localparam logic [15:0] OFS_S_LAST    = 16'h0102;
  localparam logic [15:0] OFS_C_FIRST   = 16'h0103;
  localparam logic [15:0] OFS_C_LAST    = 16'h0108;
  localparam logic [15:0] OFS_SEQ_FIRST = 16'h0e10;
  localparam logic [15:0] OFS_SEQ_LAST  = 16'h0e3f;

  // field layout
  localparam int unsigned S_BYTES      = 3;
  localparam int unsigned C_BYTES      = 6;
  localparam int unsigned BIT_READBACK = 0;
  localparam int unsigned BIT_COMMIT   = 0;

  // reset values
  localparam logic [7:0] RST_PORT_CTL = 8'h10;
  localparam logic [7:0] RST_BYTE     = 8'h00;
  // identity bytes: values are arbitrary
  localparam logic [7:0] REV_ID       = 8'h5a;
  localparam logic [7:0] DEV_ID       = 8'hc3;

  // core commit clock: system clock divided by 32
  localparam int unsigned CORE_DIV    = 32;
  localparam logic [4:0]  CORE_DIV_TOP = 5'h1f;

  // access classes
  typedef enum logic [2:0] {
    CLS_NONE, CLS_BUF_E, CLS_AUTO_E, CLS_RO, CLS_ACT_S, CLS_ACT_C, CLS_REG
  } srb_class_type;

  // one byte access from the serial engine or the memory controller
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [7:0]  wdata;
  } srb_acc_type;

  typedef struct packed {
    logic [7:0]           port_ctl;
    logic                 rb_shadow;
    logic                 commit_pend;
    logic                 pin_prev;
    logic [S_BYTES*8-1:0] shadow_s;
    logic [S_BYTES*8-1:0] active_s;
    logic [C_BYTES*8-1:0] shadow_c;
    logic [C_BYTES*8-1:0] active_c;
    logic [7:0]           status_act;
    logic [7:0]           sp_rdata;
    logic [7:0]           nv_rdata;
    logic                 commit_done;
  } srb_state_type;

  typedef struct packed {
    logic [1:0] stage;
  } srb_sync_type;

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } srb_div_type;

  // class of each address
  function automatic srb_class_type classify(input logic [15:0] a);
    srb_class_type c;
    c = CLS_REG;
    if (a > ADDR_LAST || a == OFS_RSVD) begin
      c = CLS_NONE;
    end else if (a == OFS_PORT_CTL || a == OFS_READBACK) begin
      c = CLS_BUF_E;
    end else if (a == OFS_COMMIT) begin
      c = CLS_AUTO_E;
    end else if (a == OFS_REV || a == OFS_DEV_ID || a == OFS_STATUS) begin
      c = CLS_RO;
    end else if (a >= OFS_S_FIRST && a <= OFS_S_LAST) begin
      c = CLS_ACT_S;
    end else if (a >= OFS_C_FIRST && a <= OFS_C_LAST) begin
      c = CLS_ACT_C;
    end
    return c;
  endfunction

endpackage

// ---- logic/srb_sync2.sv ----
`timescale 1ns/10ps
// two flop level synchroniser for a pin input
module srb_sync2 (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // level in and out
  input  wire logic async_i,
  output logic      sync_o
);

  srb_pkg::srb_sync_type state_q;
  srb_pkg::srb_sync_type state_d;

  // first stage only feeds the second
  always_comb begin
    state_d = state_q;
    state_d.stage = {state_q.stage[0], async_i};
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_o = state_q.stage[1];

endmodule

// ---- logic/srb_div32.sv ----
`timescale 1ns/10ps
// one cycle enable every 32 system clocks
module srb_div32 (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  // enable out
  output logic      tick_o
);

  srb_pkg::srb_div_type state_q;
  srb_pkg::srb_div_type state_d;

  // free running count, tick on wrap
  always_comb begin
    state_d      = state_q;
    state_d.cnt  = state_q.cnt + 5'h01;
    state_d.tick = (state_q.cnt == srb_pkg::CORE_DIV_TOP);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign tick_o = state_q.tick;

endmodule

// ---- logic/srb_bank.sv ----
`timescale 1ns/10ps
// Functional notes
// - addresses 0x0000 to 0x0e3f decode, one byte each, except reserved 0x0001.
// - multi-byte fields: lowest address holds the least significant byte.
// - sequence area 0x0e10-0x0e3f is kept byte-wise, no field assembly.
// - direct buffered registers act on their outputs immediately.
// - shadows behind active registers change nothing until a commit.
// - commit from writing one to bit 0 of 0x0005 or the pin.
// - serial-class actives load on the system clock at a register or pin commit.
// - core-class actives load on the system clock divided by 32.
// - bit 0 of 0x0004 picks shadow (1) or active (0) readback.
// - read-only active status refreshes only on commit; host commits first.
// - autoclear commit bit stays set until its action completes.
// - the most restrictive applying access class wins.
// - denied or missing registers read zero and ignore writes.
// - regular registers belong only to the memory controller while it is busy.
// - read-only registers stay readable, memory controller busy or not.
// - excluded and read-only registers never reach the memory controller.
module srb_bank (
  // clock and reset
  input  wire logic                 clk_sys_i,
  input  wire logic                 rst_n_i,
  // serial port byte accesses
  input  wire srb_pkg::srb_acc_type sp_req_i,
  output logic [7:0]                sp_rdata_o,
  // memory controller byte accesses
  input  wire logic                 nv_busy_i,
  input  wire srb_pkg::srb_acc_type nv_req_i,
  output logic [7:0]                nv_rdata_o,
  // multifunction pin set up as commit input
  input  wire logic                 commit_pin_i,
  // live device status captured on commit
  input  wire logic [7:0]           status_i,
  // outputs to device functions
  output logic [7:0]                port_ctl_o,
  output logic [23:0]               cfg_s_o,
  output logic [47:0]               cfg_c_o,
  output logic                      commit_pend_o,
  output logic                      commit_done_o
);

  srb_pkg::srb_state_type state_q;
  srb_pkg::srb_state_type state_d;

  // regular bytes; control bytes live in the state struct
  logic [7:0] mem_q [0:srb_pkg::MEM_DEPTH-1];

  logic                  pin_sync;
  logic                  core_tick;
  srb_pkg::srb_class_type sp_cls;
  srb_pkg::srb_class_type nv_cls;
  logic                  sp_ok;
  logic                  nv_ok;
  logic                  sp_wr_ok;
  logic                  nv_wr_ok;
  logic                  commit_req;
  logic                  mem_we;
  logic [11:0]           mem_waddr;
  logic [7:0]            mem_wdata;
  logic [7:0]            sp_mem_rd;
  logic [7:0]            nv_mem_rd;

  // pin passes two flops before anything looks at it
  srb_sync2 u_pin_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   (commit_pin_i),
    .sync_o    (pin_sync)
  );

  // enable pulse for core-class commits
  srb_div32 u_core_div (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .tick_o    (core_tick)
  );

  // byte index inside an active field
  function automatic int unsigned fld_idx(input logic [15:0] a, input logic [15:0] base);
    logic [15:0] d;
    d = a - base;
    return int'(d);
  endfunction

  // readback of one byte for an access already granted
  function automatic logic [7:0] rd_byte(
    input logic [15:0]            a,
    input srb_pkg::srb_class_type c,
    input srb_pkg::srb_state_type s,
    input logic [7:0]             memb
  );
    logic [7:0] b;
    int unsigned i;
    b = srb_pkg::RST_BYTE;
    i = 0;
    case (c)
      srb_pkg::CLS_BUF_E: begin
        if (a == srb_pkg::OFS_PORT_CTL) begin
          b = s.port_ctl;
        end else begin
          b = {7'h00, s.rb_shadow};
        end
      end
      srb_pkg::CLS_AUTO_E: begin
        b = {7'h00, s.commit_pend};
      end
      srb_pkg::CLS_RO: begin
        if (a == srb_pkg::OFS_REV) begin
          b = srb_pkg::REV_ID;
        end else if (a == srb_pkg::OFS_DEV_ID) begin
          b = srb_pkg::DEV_ID;
        end else begin
          b = s.status_act;
        end
      end
      srb_pkg::CLS_ACT_S: begin
        i = fld_idx(a, srb_pkg::OFS_S_FIRST);
        b = s.rb_shadow ? s.shadow_s[i*8 +: 8] : s.active_s[i*8 +: 8];
      end
      srb_pkg::CLS_ACT_C: begin
        i = fld_idx(a, srb_pkg::OFS_C_FIRST);
        b = s.rb_shadow ? s.shadow_c[i*8 +: 8] : s.active_c[i*8 +: 8];
      end
      srb_pkg::CLS_REG: begin
        b = memb;
      end
      default: begin
        b = srb_pkg::RST_BYTE;
      end
    endcase
    return b;
  endfunction

  // classes of the two requesters
  assign sp_cls = srb_pkg::classify(sp_req_i.addr);
  assign nv_cls = srb_pkg::classify(nv_req_i.addr);

  // serial side: missing always denied, busy controller locks regular kinds
  always_comb begin
    sp_ok = 1'b0;
    case (sp_cls)
      srb_pkg::CLS_NONE: begin
        sp_ok = 1'b0;
      end
      srb_pkg::CLS_RO, srb_pkg::CLS_BUF_E, srb_pkg::CLS_AUTO_E: begin
        sp_ok = 1'b1;
      end
      default: begin
        sp_ok = !nv_busy_i;
      end
    endcase
  end

  // controller side: only while busy, never excluded or read-only kinds
  always_comb begin
    nv_ok = 1'b0;
    case (nv_cls)
      srb_pkg::CLS_REG, srb_pkg::CLS_ACT_S, srb_pkg::CLS_ACT_C: begin
        nv_ok = nv_busy_i;
      end
      default: begin
        nv_ok = 1'b0;
      end
    endcase
  end

  // writes to read-only bytes are dropped; stricter class wins
  assign sp_wr_ok = sp_req_i.wr && sp_ok && (sp_cls != srb_pkg::CLS_RO);
  assign nv_wr_ok = nv_req_i.wr && nv_ok;

  // commit from the register bit or the pin rising
  assign commit_req = (sp_wr_ok && sp_req_i.addr == srb_pkg::OFS_COMMIT
                       && sp_req_i.wdata[srb_pkg::BIT_COMMIT])
                      || (pin_sync && !state_q.pin_prev);

  // regular byte store: owners never overlap, so one write port suffices
  always_comb begin
    mem_we    = 1'b0;
    mem_waddr = 12'h000;
    mem_wdata = 8'h00;
    if (nv_wr_ok && nv_cls == srb_pkg::CLS_REG) begin
      mem_we    = 1'b1;
      mem_waddr = nv_req_i.addr[11:0];
      mem_wdata = nv_req_i.wdata;
    end else if (sp_wr_ok && sp_cls == srb_pkg::CLS_REG) begin
      mem_we    = 1'b1;
      mem_waddr = sp_req_i.addr[11:0];
      mem_wdata = sp_req_i.wdata;
    end
  end

  // sequence area is stored byte for byte, never folded into a field
  always_ff @(posedge clk_sys_i) begin
    if (mem_we) begin
      mem_q[mem_waddr] <= mem_wdata;
    end
  end

  // guarded index keeps out-of-range reads off the array
  assign sp_mem_rd = (sp_cls == srb_pkg::CLS_REG) ? mem_q[sp_req_i.addr[11:0]] : 8'h00;
  assign nv_mem_rd = (nv_cls == srb_pkg::CLS_REG) ? mem_q[nv_req_i.addr[11:0]] : 8'h00;

  // next state of control bytes, commits and read data
  always_comb begin
    int unsigned j;
    j = 0;
    state_d = state_q;
    state_d.pin_prev    = pin_sync;
    state_d.commit_done = 1'b0;
    // shadow writes; the controller only reaches shadow copies
    if (nv_wr_ok && nv_cls == srb_pkg::CLS_ACT_S) begin
      j = fld_idx(nv_req_i.addr, srb_pkg::OFS_S_FIRST);
      state_d.shadow_s[j*8 +: 8] = nv_req_i.wdata;
    end else if (nv_wr_ok && nv_cls == srb_pkg::CLS_ACT_C) begin
      j = fld_idx(nv_req_i.addr, srb_pkg::OFS_C_FIRST);
      state_d.shadow_c[j*8 +: 8] = nv_req_i.wdata;
    end
    if (sp_wr_ok) begin
      if (sp_cls == srb_pkg::CLS_ACT_S) begin
        j = fld_idx(sp_req_i.addr, srb_pkg::OFS_S_FIRST);
        state_d.shadow_s[j*8 +: 8] = sp_req_i.wdata;
      end else if (sp_cls == srb_pkg::CLS_ACT_C) begin
        j = fld_idx(sp_req_i.addr, srb_pkg::OFS_C_FIRST);
        state_d.shadow_c[j*8 +: 8] = sp_req_i.wdata;
      end else if (sp_req_i.addr == srb_pkg::OFS_PORT_CTL) begin
        state_d.port_ctl = sp_req_i.wdata;
      end else if (sp_req_i.addr == srb_pkg::OFS_READBACK) begin
        state_d.rb_shadow = sp_req_i.wdata[srb_pkg::BIT_READBACK];
      end
    end
    // core class waits for the divided clock; bit clears when done
    if (state_q.commit_pend && core_tick) begin
      state_d.active_c    = state_q.shadow_c;
      state_d.commit_pend = 1'b0;
      state_d.commit_done = 1'b1;
    end
    // serial class loads at once; a new commit beats the clear
    if (commit_req) begin
      state_d.active_s    = state_q.shadow_s;
      state_d.status_act  = status_i;
      state_d.commit_pend = 1'b1;
    end
    // read data holds until the next granted or denied read
    if (sp_req_i.rd) begin
      state_d.sp_rdata = sp_ok ? rd_byte(sp_req_i.addr, sp_cls, state_q, sp_mem_rd)
                               : srb_pkg::RST_BYTE;
    end
    if (nv_req_i.rd) begin
      state_d.nv_rdata = nv_ok ? rd_byte(nv_req_i.addr, nv_cls, state_q, nv_mem_rd)
                               : srb_pkg::RST_BYTE;
    end
  end

  // control state register
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q          <= '0;
      state_q.port_ctl <= srb_pkg::RST_PORT_CTL;
    end else begin
      state_q <= state_d;
    end
  end

  // outputs; fields little end first at the lowest address
  assign sp_rdata_o    = state_q.sp_rdata;
  assign nv_rdata_o    = state_q.nv_rdata;
  assign port_ctl_o    = state_q.port_ctl;
  assign cfg_s_o       = state_q.active_s;
  assign cfg_c_o       = state_q.active_c;
  assign commit_pend_o = state_q.commit_pend;
  assign commit_done_o = state_q.commit_done;

  // checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  property p_s_commit;
    commit_req |=> (cfg_s_o == $past(state_q.shadow_s));
  endproperty
  a_s_commit: assert property (p_s_commit)
    else $error("serial-class active did not load on commit");

  property p_s_hold;
    !commit_req |=> $stable(cfg_s_o);
  endproperty
  a_s_hold: assert property (p_s_hold)
    else $error("serial-class active changed without commit");

  property p_c_hold;
    !(core_tick && state_q.commit_pend) |=> $stable(cfg_c_o);
  endproperty
  a_c_hold: assert property (p_c_hold)
    else $error("core-class active changed off the divided clock");

  property p_tick_gap;
    core_tick |=> !core_tick [*8];
  endproperty
  a_tick_gap: assert property (p_tick_gap)
    else $error("divided clock tick too close");

  // the bit may only drop on the edge that also flags the finished core load
  property p_autoclr;
    $fell(commit_pend_o) |-> commit_done_o;
  endproperty
  a_autoclr: assert property (p_autoclr)
    else $error("commit bit cleared before completion");

  property p_cmt_set;
    commit_req |=> commit_pend_o;
  endproperty
  a_cmt_set: assert property (p_cmt_set)
    else $error("commit bit not set by commit");

  // a fresh commit inside the window restarts the wait, so it also ends it
  property p_autoclr_end;
    commit_req |-> ##[1:33] (!commit_pend_o || commit_req);
  endproperty
  a_autoclr_end: assert property (p_autoclr_end)
    else $error("commit bit not cleared within one divided period");

  property p_missing_rd;
    (sp_req_i.rd && sp_cls == srb_pkg::CLS_NONE) |=> (sp_rdata_o == 8'h00);
  endproperty
  a_missing_rd: assert property (p_missing_rd)
    else $error("nonexistent register read not zero");

  property p_busy_deny;
    (sp_req_i.rd && nv_busy_i && sp_cls == srb_pkg::CLS_REG) |=> (sp_rdata_o == 8'h00);
  endproperty
  a_busy_deny: assert property (p_busy_deny)
    else $error("serial read of regular register granted while busy");

  property p_ro_rd;
    (sp_req_i.rd && sp_req_i.addr == srb_pkg::OFS_DEV_ID) |=> (sp_rdata_o == srb_pkg::DEV_ID);
  endproperty
  a_ro_rd: assert property (p_ro_rd)
    else $error("read-only register not readable");

  property p_nv_excl;
    (nv_req_i.rd && (nv_cls == srb_pkg::CLS_RO || nv_cls == srb_pkg::CLS_BUF_E))
      |=> (nv_rdata_o == 8'h00);
  endproperty
  a_nv_excl: assert property (p_nv_excl)
    else $error("excluded register reached by memory controller");

  property p_rb_active;
    (sp_req_i.rd && sp_ok && sp_req_i.addr == srb_pkg::OFS_S_FIRST && !state_q.rb_shadow)
      |=> (sp_rdata_o == $past(state_q.active_s[7:0]));
  endproperty
  a_rb_active: assert property (p_rb_active)
    else $error("readback select ignored");

endmodule

// ---- verification/srb_host_model.sv ----
`timescale 1ns/10ps
// byte access master standing in for the serial engine or the memory controller
module srb_host_model (
  // clock
  input  wire logic            clk_sys_i,
  // access out, read byte back
  output srb_pkg::srb_acc_type req_o,
  input  wire logic [7:0]      rdata_i
);
  // idle until the first access
  initial begin
    req_o = '0;
  end

  // one byte access, address high byte and low byte handed over together in one cycle
  task automatic access(input logic w, input logic [7:0] a_hi, input logic [7:0] a_lo,
                        input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys_i);
    #1;
    req_o.addr  = {a_hi, a_lo};
    req_o.wdata = d;
    req_o.wr    = w;
    req_o.rd    = !w;
    @(posedge clk_sys_i);
    #1;
    // released strobes drop low; address and data lines show inverted values so stale data never looks valid
    req_o.wr    = 1'b0;
    req_o.rd    = 1'b0;
    req_o.addr  = ~req_o.addr;
    req_o.wdata = ~req_o.wdata;
    @(posedge clk_sys_i);
    #1;
    q = rdata_i;
  endtask
endmodule

// ---- verification/testbench.sv ----
`timescale 1ns/10ps
// self-checking bench for the shadowed register bank
module testbench;
  logic                 clk_sys_i;
  logic                 rst_n_i;
  srb_pkg::srb_acc_type sp_req;
  srb_pkg::srb_acc_type nv_req;
  logic [7:0]           sp_rdata;
  logic [7:0]           nv_rdata;
  logic                 nv_busy;
  logic                 commit_pin;
  logic [7:0]           status;
  logic [7:0]           port_ctl;
  logic [23:0]          cfg_s;
  logic [47:0]          cfg_c;
  logic                 commit_pend;
  logic                 commit_done;
  int                   miscompares;
  int                   comparisons;
  int                   done_count;

  srb_bank srb_bank_inst (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sp_req_i(sp_req), .sp_rdata_o(sp_rdata),
    .nv_busy_i(nv_busy), .nv_req_i(nv_req), .nv_rdata_o(nv_rdata),
    .commit_pin_i(commit_pin), .status_i(status), .port_ctl_o(port_ctl), .cfg_s_o(cfg_s),
    .cfg_c_o(cfg_c), .commit_pend_o(commit_pend), .commit_done_o(commit_done)
  );
  // two masters: serial engine side and memory controller side
  srb_host_model srb_host_model_sp_inst (
    .clk_sys_i(clk_sys_i), .req_o(sp_req), .rdata_i(sp_rdata)
  );
  srb_host_model srb_host_model_nv_inst (
    .clk_sys_i(clk_sys_i), .req_o(nv_req), .rdata_i(nv_rdata)
  );

  // 25 MHz system clock
  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  // core loads show only as a one-cycle pulse, so count them as they pass
  always @(posedge clk_sys_i) begin
    if (commit_done === 1'b1) begin
      done_count++;
    end
  end

  task automatic wrap_up();
    $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] exp, input logic [47:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task automatic sp_wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    srb_host_model_sp_inst.access(1'b1, a[15:8], a[7:0], d, q);
  endtask

  task automatic sp_rd(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    srb_host_model_sp_inst.access(1'b0, a[15:8], a[7:0], 8'h00, q);
    chk({40'h0, exp}, {40'h0, q});
  endtask

  task automatic nv_wr(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] q;
    srb_host_model_nv_inst.access(1'b1, a[15:8], a[7:0], d, q);
  endtask

  task automatic nv_rd(input logic [15:0] a, input logic [7:0] exp);
    logic [7:0] q;
    srb_host_model_nv_inst.access(1'b0, a[15:8], a[7:0], 8'h00, q);
    chk({40'h0, exp}, {40'h0, q});
  endtask

  // core tick comes at most every 32 cycles; 40 leaves margin
  task automatic wait_done(input int n0);
    int i;
    for (i = 0; i < 40 && done_count == n0; i++) begin
      @(posedge clk_sys_i);
    end
    #1;
    if (done_count == n0) begin
      $display("ERROR t=%0t exp=%h got=%h", $time, n0 + 1, done_count);
      miscompares++;
      wrap_up();
    end
  endtask

  task automatic t_reset();
    chk(48'h10, {40'h0, port_ctl});
    chk(48'h0, {24'h0, cfg_s});
    chk(48'h0, cfg_c);
    sp_rd(16'h0000, srb_pkg::RST_PORT_CTL);
    sp_rd(16'h0002, srb_pkg::REV_ID);
    sp_rd(16'h0003, srb_pkg::DEV_ID);
    sp_rd(16'h0004, 8'h00);
    sp_rd(16'h0005, 8'h00);
  endtask

  task automatic t_direct();
    sp_wr(16'h0000, 8'h5a);
    chk(48'h5a, {40'h0, port_ctl});
  endtask

  task automatic t_commit();
    int i;
    int n0;
    status = 8'ha5;
    for (i = 0; i < 9; i++) begin
      sp_wr(16'h0100 + 16'(i), 8'(8'h11 * (i + 1)));
    end
    chk(48'h0, {24'h0, cfg_s});
    chk(48'h0, cfg_c);
    sp_rd(16'h0100, 8'h00);
    sp_wr(16'h0004, 8'h01);
    sp_rd(16'h0100, 8'h11);
    sp_rd(16'h0004, 8'h01);
    sp_wr(16'h0004, 8'h00);
    n0 = done_count;
    sp_wr(16'h0005, 8'h01);
    chk(48'h332211, {24'h0, cfg_s});
    wait_done(n0);
    chk(48'h998877665544, cfg_c);
    chk(48'h0, {47'h0, commit_pend});
    sp_rd(16'h0005, 8'h00);
    sp_rd(16'h0103, 8'h44);
    sp_rd(16'h0006, 8'ha5);
  endtask

  task automatic t_pin();
    int i;
    int n0;
    status = 8'h3c;
    sp_wr(16'h0100, 8'h5e);
    chk(48'h11, {40'h0, cfg_s[7:0]});
    n0 = done_count;
    commit_pin = 1'b1;
    for (i = 0; i < 8 && cfg_s[7:0] !== 8'h5e; i++) begin
      @(posedge clk_sys_i);
    end
    #1;
    chk(48'h5e, {40'h0, cfg_s[7:0]});
    commit_pin = 1'b0;
    wait_done(n0);
    sp_rd(16'h0006, 8'h3c);
  endtask

  task automatic t_denied();
    sp_wr(16'h0001, 8'hff);
    sp_rd(16'h0001, 8'h00);
    sp_rd(16'h0e40, 8'h00);
    sp_wr(16'h0e3f, 8'h77);
    sp_rd(16'h0e3f, 8'h77);
    sp_wr(16'h0002, 8'hff);
    sp_rd(16'h0002, srb_pkg::REV_ID);
    sp_wr(16'h0e10, 8'hab);
    sp_wr(16'h0e11, 8'hcd);
    sp_rd(16'h0e10, 8'hab);
    sp_rd(16'h0e11, 8'hcd);
  endtask

  task automatic t_nv();
    nv_rd(16'h0200, 8'h00);
    nv_busy = 1'b1;
    sp_wr(16'h0200, 8'h12);
    sp_rd(16'h0200, 8'h00);
    sp_rd(16'h0002, srb_pkg::REV_ID);
    nv_wr(16'h0200, 8'h34);
    nv_rd(16'h0200, 8'h34);
    nv_rd(16'h0000, 8'h00);
    nv_rd(16'h0002, 8'h00);
    nv_wr(16'h0000, 8'hff);
    chk(48'h5a, {40'h0, port_ctl});
    nv_wr(16'h0101, 8'h77);
    sp_rd(16'h0101, 8'h00);
    nv_busy = 1'b0;
    sp_rd(16'h0200, 8'h34);
    chk(48'h22, {40'h0, cfg_s[15:8]});
    sp_wr(16'h0004, 8'h01);
    sp_rd(16'h0101, 8'h77);
    sp_wr(16'h0004, 8'h00);
  endtask

  // main sequence
  initial begin
    miscompares = 0;
    comparisons = 0;
    done_count = 0;
    rst_n_i = 1'b0;
    nv_busy = 1'b0;
    commit_pin = 1'b0;
    status = 8'h00;
    repeat (5) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_direct();
    t_commit();
    t_pin();
    t_denied();
    t_nv();
    wrap_up();
  end
endmodule
